/* File: inc/aac_pkg.sv */
// Behaviour
// - Input selection register at 16h, reset 01h, one read/write byte.
// - Positive selector bits 7:4, reset 0; codes 0-9 pins, 1010 common pin.
// - Positive codes 1011-1111: temperature, analog, digital, test, open.
// - Negative selector bits 3:0, reset 1; codes 0-9 route analog inputs.
// - Negative codes 1011-1111: temperature, analog, digital, test, open.
// - Offset word 16-bit two's complement, low byte 17h, high 18h, reset 0.
// - Offset word left-shifted 8 bits to align with the upper 16 of the 24 result bits.
// - Aligned offset subtracted from each result before gain scaling.
// - Gain word 16-bit unsigned, low 19h reset 00h, high 1Ah reset 40h.
// - Scale factor is gain word divided by 4000h; reset gives unity.
// - Offset-corrected result times scale factor, clamped to the 24-bit range, is the calibrated output.
package aac_pkg;

	// ----------------------------------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_INPUT_SELECT = 8'h16;
	localparam logic [7:0] IDX_OFFSET_LOW   = 8'h17;
	localparam logic [7:0] IDX_OFFSET_HIGH  = 8'h18;
	localparam logic [7:0] IDX_GAIN_LOW     = 8'h19;
	localparam logic [7:0] IDX_GAIN_HIGH    = 8'h1A;
	localparam logic [7:0] IDX_RESULT       = 8'h1B;
	localparam logic [7:0] IDX_STATUS       = 8'h1C;
	localparam int         ADDR_WIDTH       = 10;
	localparam int         ADDR_SHIFT       = 2;

	// ----------------------------------------------------------------
	// Reset values and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_INPUT_SELECT = 8'h01;
	localparam logic [7:0] RST_OFFSET_LOW   = 8'h00;
	localparam logic [7:0] RST_OFFSET_HIGH  = 8'h00;
	localparam logic [7:0] RST_GAIN_LOW     = 8'h00;
	localparam logic [7:0] RST_GAIN_HIGH    = 8'h40;
	localparam int         POS_SEL_MSB      = 7;
	localparam int         POS_SEL_LSB      = 4;
	localparam int         NEG_SEL_MSB      = 3;
	localparam int         NEG_SEL_LSB      = 0;

	// ----------------------------------------------------------------
	// Arithmetic widths
	// ----------------------------------------------------------------
	localparam int RESULT_WIDTH = 24;
	localparam int WORD_WIDTH   = 16;
	localparam int OFFSET_SHIFT = RESULT_WIDTH - WORD_WIDTH;
	localparam int GAIN_SHIFT   = 14;
	localparam int PROD_WIDTH   = 43;
	localparam logic signed [PROD_WIDTH-1:0] SAT_MAX = 43'sh7FFFFF;
	localparam logic signed [PROD_WIDTH-1:0] SAT_MIN = -43'sh800000;

	// ----------------------------------------------------------------
	// Input source codes
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		SRC_AIN0   = 4'h0,
		SRC_AIN1   = 4'h1,
		SRC_AIN2   = 4'h2,
		SRC_AIN3   = 4'h3,
		SRC_AIN4   = 4'h4,
		SRC_AIN5   = 4'h5,
		SRC_AIN6   = 4'h6,
		SRC_AIN7   = 4'h7,
		SRC_AIN8   = 4'h8,
		SRC_AIN9   = 4'h9,
		SRC_COMMON = 4'hA,
		SRC_TEMP   = 4'hB,
		SRC_AVDD   = 4'hC,
		SRC_DVDD   = 4'hD,
		SRC_TEST   = 4'hE,
		SRC_OPEN   = 4'hF
	} aac_src_type;

	// ----------------------------------------------------------------
	// Calibration pipeline states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SUB   = 2'b01,
		ST_MUL   = 2'b10,
		ST_SAT   = 2'b11
	} aac_state_type;

endpackage : aac_pkg

/* File: design/aac_calib.sv */
`timescale 1ns/100ps
// Offset and gain correction of one auxiliary converter result.
module aac_calib (
	// Clock and reset.
	input  wire logic                clk,
	input  wire logic                rst,
	// Raw sample in.
	input  wire logic                raw_valid,
	input  wire logic signed [23:0]  raw_data,
	// Calibration words.
	input  wire logic signed [15:0]  aux_offset_word,
	input  wire logic        [15:0]  aux_gain_word,
	// Calibrated sample out.
	output logic                     cal_valid,
	output logic signed [23:0]       cal_data,
	output logic                     cal_clipped,
	output logic                     busy
);

	// ----------------------------------------------------------------
	// State and datapath registers
	// ----------------------------------------------------------------
	aac_pkg::aac_state_type state_reg;
	logic signed [24:0] diff_reg;
	logic signed [aac_pkg::PROD_WIDTH-1:0] prod_reg;
	logic signed [24:0] aligned_offset;
	logic signed [aac_pkg::PROD_WIDTH-1:0] scaled;

	assign aligned_offset = 25'(aux_offset_word) <<< aac_pkg::OFFSET_SHIFT;
	assign scaled = prod_reg >>> aac_pkg::GAIN_SHIFT;
	assign busy   = (state_reg != aac_pkg::ST_IDLE);

	// Sequencer: subtract, multiply, then saturate.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= aac_pkg::ST_IDLE;
		end else begin
			case (state_reg)
				aac_pkg::ST_IDLE: begin
					if (raw_valid) begin
						state_reg <= aac_pkg::ST_SUB;
					end
				end
				aac_pkg::ST_SUB: state_reg <= aac_pkg::ST_MUL;
				aac_pkg::ST_MUL: state_reg <= aac_pkg::ST_SAT;
				aac_pkg::ST_SAT: state_reg <= aac_pkg::ST_IDLE;
				default:         state_reg <= aac_pkg::ST_IDLE;
			endcase
		end
	end

	// Datapath registers for each stage.
	always_ff @(posedge clk) begin
		if (rst) begin
			diff_reg <= 25'sh0000000;
			prod_reg <= '0;
		end else begin
			if (state_reg == aac_pkg::ST_IDLE && raw_valid) begin
				diff_reg <= 25'(raw_data) - aligned_offset;
			end
			if (state_reg == aac_pkg::ST_MUL) begin
				prod_reg <= aac_pkg::PROD_WIDTH'(diff_reg)
				          * $signed({1'b0, aux_gain_word});
			end
		end
	end

	// Output stage with clamping to the result range.
	always_ff @(posedge clk) begin
		if (rst) begin
			cal_valid   <= 1'b0;
			cal_data    <= 24'sh000000;
			cal_clipped <= 1'b0;
		end else begin
			cal_valid <= (state_reg == aac_pkg::ST_SAT);
			if (state_reg == aac_pkg::ST_SAT) begin
				if (scaled > aac_pkg::SAT_MAX) begin
					cal_data    <= 24'sh7FFFFF;
					cal_clipped <= 1'b1;
				end else if (scaled < aac_pkg::SAT_MIN) begin
					cal_data    <= 24'sh800000;
					cal_clipped <= 1'b1;
				end else begin
					cal_data    <= scaled[23:0];
					cal_clipped <= 1'b0;
				end
			end
		end
	end

endmodule : aac_calib

/* File: design/aac_top.sv */
`timescale 1ns/100ps
// Auxiliary converter input selection and calibration register bank.
module aac_top (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst,
	// APB slave.
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [9:0]   paddr,
	input  wire logic [31:0]  pwdata,
	input  wire logic [3:0]   pstrb,
	output logic              pready,
	output logic [31:0]       prdata,
	output logic              pslverr,
	// Converter raw result, same clock domain.
	input  wire logic         raw_valid,
	input  wire logic [23:0]  raw_data,
	// Analog switch controls.
	output logic [3:0]        aux_pos_selector,
	output logic [3:0]        aux_neg_selector,
	output logic [15:0]       pos_route_onehot,
	output logic [15:0]       neg_route_onehot,
	// Calibrated result.
	output logic              cal_valid,
	output logic [23:0]       cal_data
);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [7:0]  input_select_reg;
	logic [7:0]  offset_low_reg;
	logic [7:0]  offset_high_reg;
	logic [7:0]  gain_low_reg;
	logic [7:0]  gain_high_reg;
	logic [23:0] result_reg;
	logic        ready_reg;
	logic        clipped_reg;
	logic        cal_clipped;
	logic        calib_busy;
	logic signed [23:0] cal_data_int;
	logic [7:0]  word_index;
	logic        addr_ok;
	logic        wr_en;
	logic        rd_en;

	// Decode a byte address to a register index.
	function automatic logic [7:0] aac_index(input logic [9:0] a);
		aac_index = a[9:aac_pkg::ADDR_SHIFT];
	endfunction : aac_index

	// Whether an index names a mapped register.
	function automatic logic aac_mapped(input logic [7:0] i);
		aac_mapped = (i >= aac_pkg::IDX_INPUT_SELECT)
		          && (i <= aac_pkg::IDX_STATUS);
	endfunction : aac_mapped

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Zero wait states; unmapped or misaligned gives an error.
	assign word_index = aac_index(paddr);
	assign addr_ok    = aac_mapped(word_index) && (paddr[1:0] == 2'b00);
	assign pready     = 1'b1;
	assign pslverr    = psel && penable && !addr_ok;
	assign wr_en      = psel && penable && pwrite && addr_ok && pstrb[0];
	assign rd_en      = psel && penable && !pwrite && addr_ok;

	// Input selection byte.
	always_ff @(posedge clk) begin
		if (rst) begin
			input_select_reg <= aac_pkg::RST_INPUT_SELECT;
		end else if (wr_en && word_index == aac_pkg::IDX_INPUT_SELECT) begin
			input_select_reg <= pwdata[7:0];
		end
	end

	// Offset word bytes.
	always_ff @(posedge clk) begin
		if (rst) begin
			offset_low_reg  <= aac_pkg::RST_OFFSET_LOW;
			offset_high_reg <= aac_pkg::RST_OFFSET_HIGH;
		end else if (wr_en) begin
			if (word_index == aac_pkg::IDX_OFFSET_LOW) begin
				offset_low_reg <= pwdata[7:0];
			end
			if (word_index == aac_pkg::IDX_OFFSET_HIGH) begin
				offset_high_reg <= pwdata[7:0];
			end
		end
	end

	// Gain word bytes.
	always_ff @(posedge clk) begin
		if (rst) begin
			gain_low_reg  <= aac_pkg::RST_GAIN_LOW;
			gain_high_reg <= aac_pkg::RST_GAIN_HIGH;
		end else if (wr_en) begin
			if (word_index == aac_pkg::IDX_GAIN_LOW) begin
				gain_low_reg <= pwdata[7:0];
			end
			if (word_index == aac_pkg::IDX_GAIN_HIGH) begin
				gain_high_reg <= pwdata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Input routing
	// ----------------------------------------------------------------
	// positive and negative fields
	assign aux_pos_selector = input_select_reg[aac_pkg::POS_SEL_MSB:
	                                           aac_pkg::POS_SEL_LSB];
	assign aux_neg_selector = input_select_reg[aac_pkg::NEG_SEL_MSB:
	                                           aac_pkg::NEG_SEL_LSB];

	// One switch enable per source code, both sides, except none for the common code on the negative side.
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_route
			assign pos_route_onehot[g] = (aux_pos_selector == 4'(g));
			assign neg_route_onehot[g] = (aux_neg_selector == 4'(g))
			                          && (4'(g) != aac_pkg::SRC_COMMON);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Calibration
	// ----------------------------------------------------------------
	aac_calib u_calib (
		.clk             (clk),
		.rst             (rst),
		.raw_valid       (raw_valid),
		.raw_data        ($signed(raw_data)),
		.aux_offset_word ($signed({offset_high_reg, offset_low_reg})),
		.aux_gain_word   ({gain_high_reg, gain_low_reg}),
		.cal_valid       (cal_valid),
		.cal_data        (cal_data_int),
		.cal_clipped     (cal_clipped),
		.busy            (calib_busy)
	);
	assign cal_data = cal_data_int;

	// Last result and status; a new result wins over a read clear.
	always_ff @(posedge clk) begin
		if (rst) begin
			result_reg  <= 24'h000000;
			ready_reg   <= 1'b0;
			clipped_reg <= 1'b0;
		end else if (cal_valid) begin
			result_reg  <= cal_data_int;
			ready_reg   <= 1'b1;
			clipped_reg <= cal_clipped;
		end else if (rd_en && word_index == aac_pkg::IDX_RESULT) begin
			ready_reg <= 1'b0;
		end
	end

	// Read data, driven from the registers during the access phase.
	always_comb begin
		prdata = 32'h00000000;
		if (rd_en) begin
			case (word_index)
				aac_pkg::IDX_INPUT_SELECT: prdata[7:0] = input_select_reg;
				aac_pkg::IDX_OFFSET_LOW:   prdata[7:0] = offset_low_reg;
				aac_pkg::IDX_OFFSET_HIGH:  prdata[7:0] = offset_high_reg;
				aac_pkg::IDX_GAIN_LOW:     prdata[7:0] = gain_low_reg;
				aac_pkg::IDX_GAIN_HIGH:    prdata[7:0] = gain_high_reg;
				aac_pkg::IDX_RESULT:       prdata[23:0] = result_reg;
				aac_pkg::IDX_STATUS: begin
					prdata[2:0] = {calib_busy, clipped_reg, ready_reg};
				end
				default:                   prdata = 32'h00000000;
			endcase
		end
	end

endmodule : aac_top

/* File: verif/aac_top_asserts.sv */
`timescale 1ns/100ps
// Port-level checks of the selection and calibration block.
module aac_top_asserts (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        rst,
	// APB slave side.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [9:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pready,
	input wire logic        pslverr,
	// Converter and outputs.
	input wire logic        raw_valid,
	input wire logic [3:0]  aux_pos_selector,
	input wire logic [3:0]  aux_neg_selector,
	input wire logic [15:0] pos_route_onehot,
	input wire logic [15:0] neg_route_onehot,
	input wire logic        cal_valid,
	input wire logic [23:0] cal_data
);
	// Byte address of the selection register.
	localparam logic [9:0] SEL_ADDR = {aac_pkg::IDX_INPUT_SELECT, 2'b00};
	// All checks share the one clock and its reset.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_reset_sel;
		$fell(rst) |-> aux_pos_selector == 4'h0 && aux_neg_selector == 4'h1;
	endproperty
	a_reset_sel: assert property (p_reset_sel) else $error("bad sel reset");
	property p_pos_route;
		pos_route_onehot == 16'h0001 << aux_pos_selector;
	endproperty
	a_pos_route: assert property (p_pos_route) else $error("bad pos");
	property p_neg_route;
		neg_route_onehot == ((aux_neg_selector == 4'hA) ? 16'h0000 :
			16'h0001 << aux_neg_selector);
	endproperty
	a_neg_route: assert property (p_neg_route) else $error("bad neg");
	property p_sel_write;
		psel && penable && pwrite && pstrb[0] && paddr == SEL_ADDR |=>
			{aux_pos_selector, aux_neg_selector} == $past(pwdata[7:0]);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("sel write");
	property p_sel_hold;
		!(psel && penable && pwrite) |=>
			$stable({aux_pos_selector, aux_neg_selector});
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("sel moved");
	property p_pready;
		psel && penable |-> pready;
	endproperty
	a_pready: assert property (p_pready) else $error("no ready");
	property p_misalign;
		psel && penable && paddr[1:0] != 2'b00 |-> pslverr;
	endproperty
	a_misalign: assert property (p_misalign) else $error("no error");
	property p_cal_latency;
		cal_valid |-> $past(raw_valid, 4);
	endproperty
	a_cal_latency: assert property (p_cal_latency) else $error("late");
	property p_cal_pulse;
		cal_valid |=> !cal_valid ##1 !cal_valid;
	endproperty
	a_cal_pulse: assert property (p_cal_pulse) else $error("long");
	property p_cal_hold;
		!cal_valid |-> $stable(cal_data);
	endproperty
	a_cal_hold: assert property (p_cal_hold) else $error("data moved");
endmodule : aac_top_asserts

/* File: verif/testbench.sv */
`timescale 1ns/100ps
// Self-checking bench for the selection and calibration block.
module testbench;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, re;
	logic        raw_valid, cal_valid;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, aux_pos_selector, aux_neg_selector;
	logic [15:0] pos_route_onehot, neg_route_onehot;
	logic [23:0] raw_data, cal_data;
	int          fails, n_checks;

	// Device under test, every port by name.
	aac_top i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .pready, .prdata, .pslverr, .raw_valid, .raw_data,
		.aux_pos_selector, .aux_neg_selector, .pos_route_onehot,
		.neg_route_onehot, .cal_valid, .cal_data);

	// Free-running clock.
	always #5 clk = ~clk;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [9:0] ba(input logic [7:0] idx);
		return {idx, 2'b00};
	endfunction : ba

	// Offset, then gain, then clamp to the 24-bit range.
	function automatic logic [23:0] cal_model(input logic [23:0] r,
		input logic [15:0] o, input logic [15:0] g);
		longint d;
		d = longint'($signed(r)) - (longint'($signed(o)) <<< 8);
		d = (d * longint'(g)) >>> 14;
		if (d > 64'sh7FFFFF) d = 64'sh7FFFFF;
		if (d < -64'sh800000) d = -64'sh800000;
		return d[23:0];
	endfunction : cal_model

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("unexpected %s: expected %h, seen %h", n, e, g);
			fails++;
		end
	endtask : chk

	// One APB transfer; read data and error taken at the ready edge.
	task automatic apb(input logic w, input logic [9:0] a,
		input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			fails++;
			results;
		end
		rd = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		logic [7:0] rv [7] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00,
			8'h00};
		chk("pos route", 32'h1, pos_route_onehot);
		chk("neg route", 32'h2, neg_route_onehot);
		chk("cal valid reset", 32'h0, {31'h0, cal_valid});
		chk("cal data reset", 32'h0, {8'h0, cal_data});
		for (int k = 0; k < 7; k++) begin
			apb(1'b0, ba(8'(aac_pkg::IDX_INPUT_SELECT + k)), 32'h0);
			chk("reset value", {24'h0, rv[k]}, rd);
		end
	endtask : t_reset

	// Every code on both sides, then a write without its byte strobe.
	task automatic t_mux;
		logic [3:0] p, n;
		for (int c = 0; c < 16; c++) begin
			p = c[3:0];
			n = ~p;
			apb(1'b1, ba(aac_pkg::IDX_INPUT_SELECT), {24'h0, p, n});
			chk("pos route", 32'h1 << p, pos_route_onehot);
			chk("neg route", n == 4'hA ? 0 : 32'h1 << n, neg_route_onehot);
			apb(1'b0, ba(aac_pkg::IDX_INPUT_SELECT), 32'h0);
			chk("select", {24'h0, p, n}, rd);
		end
		pstrb <= 4'hE;
		apb(1'b1, ba(aac_pkg::IDX_INPUT_SELECT), 32'h55);
		pstrb <= 4'hF;
		apb(1'b1, 10'h3FC, 32'h66);
		chk("unmapped error", 32'h1, {31'h0, re});
		apb(1'b0, 10'h059, 32'h0);
		chk("misaligned error", 32'h1, {31'h0, re});
		chk("kept select", 32'hF0, {24'h0, aux_pos_selector, aux_neg_selector});
	endtask : t_mux

	// Offset and gain cases, a busy-time offer, and clamping.
	task automatic t_cal;
		logic [23:0] cr [7] = '{24'h000400, 24'h012345, 24'h001000,
			24'hFFF000, 24'h7FFFFF, 24'h800000, 24'hFFFFFD};
		logic [15:0] co [7] = '{16'h0000, 16'h0012, 16'h0010, 16'hFFFF,
			16'h0000, 16'h7FFF, 16'h0000};
		logic [15:0] cg [7] = '{16'h4000, 16'h4000, 16'h8000, 16'h2000,
			16'hFFFF, 16'h4000, 16'h2000};
		logic        cl [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
		logic [23:0] ex;
		int i;
		for (int k = 0; k < 7; k++) begin
			apb(1'b1, ba(aac_pkg::IDX_OFFSET_LOW), {24'h0, co[k][7:0]});
			apb(1'b1, ba(aac_pkg::IDX_OFFSET_HIGH), {24'h0, co[k][15:8]});
			apb(1'b1, ba(aac_pkg::IDX_GAIN_LOW), {24'h0, cg[k][7:0]});
			apb(1'b1, ba(aac_pkg::IDX_GAIN_HIGH), {24'h0, cg[k][15:8]});
			raw_valid <= 1'b1;
			raw_data <= cr[k];
			@(posedge clk);
			raw_data <= ~cr[k];
			@(posedge clk);
			raw_valid <= 1'b0;
			for (i = 0; i < 12; i++) begin
				@(posedge clk);
				if (cal_valid === 1'b1) break;
			end
			if (i == 12) begin
				fails++;
				results;
			end
			ex = cal_model(cr[k], co[k], cg[k]);
			chk("cal data", {8'h0, ex}, {8'h0, cal_data});
			// Status shows ready and clip, reading the result clears ready.
			apb(1'b0, ba(aac_pkg::IDX_STATUS), 32'h0);
			chk("status", {30'h0, cl[k], 1'b1}, rd);
			apb(1'b0, ba(aac_pkg::IDX_RESULT), 32'h0);
			chk("result", {8'h0, ex}, rd);
			apb(1'b0, ba(aac_pkg::IDX_STATUS), 32'h0);
			chk("status", {30'h0, cl[k], 1'b0}, rd);
		end
	endtask : t_cal

	// Reset, then each scenario in turn.
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 10'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		raw_valid = 1'b0;
		raw_data = 24'h0;
		fails = 0;
		n_checks = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_mux;
		t_cal;
		// A second reset in mid-run must restore every register.
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		results;
	end
endmodule : testbench

bind aac_top aac_top_asserts i_chk (.clk, .rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .pready, .pslverr, .raw_valid,
	.aux_pos_selector, .aux_neg_selector, .pos_route_onehot,
	.neg_route_onehot, .cal_valid, .cal_data);
